// ### t1ld_consts.svh
`ifndef T1LD_CONSTS_SVH
`define T1LD_CONSTS_SVH

// register offsets on the parallel control port
`define T1LD_CTL3_OFS 8'h30
`define T1LD_INFO2_OFS 8'h31

// common_control_three field positions
`define T1LD_LIRESET_BIT 0
`define T1LD_LUP_BIT 1
`define T1LD_LDN_BIT 2
`define T1LD_ENF_BIT 3
`define T1LD_CTL3_RST 8'h00

// receive_info_two field positions
`define T1LD_RIR_TX_BIT 0
`define T1LD_RIR_RX_BIT 1

// density limits
`define T1LD_ZERO_RUN_MAX 15
`define T1LD_WIN_UNIT 8
`define T1LD_WIN_N_MAX 23
`define T1LD_HIST_LEN 192

// loop code lengths
`define T1LD_LUP_LEN 5
`define T1LD_LDN_LEN 3

// timing
`define T1LD_CLK_PERIOD_NS 25
`define T1LD_LI_RECOVER_MS 40
`define T1LD_LI_RECOVER_CYC ((`T1LD_LI_RECOVER_MS * 1000000) / `T1LD_CLK_PERIOD_NS)

`endif

// ### t1ld_pkg.sv
package t1ld_pkg;

  // loop code selection on the transmit path
  typedef enum logic [1:0] {
    T1LD_LOOP_NONE = 2'b00,
    T1LD_LOOP_UP = 2'b01,
    T1LD_LOOP_DOWN = 2'b10
  } t1ld_loop_e;

  // line interface recovery state
  typedef enum logic [0:0] {
    T1LD_LI_IDLE = 1'b0,
    T1LD_LI_RECOVER = 1'b1
  } t1ld_li_e;

endpackage : t1ld_pkg

// ### t1ld_pair_buf.sv
`timescale 1ns/1ps
module t1ld_pair_buf #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] slot0_r, slot0_nxt, slot1_r, slot1_nxt;
  logic v0_r, v0_nxt, v1_r, v1_nxt, rdy_r, rdy_nxt;
  logic push, pop;

  assign push = in_valid & rdy_r;
  assign pop = v0_r & out_ready;
  assign in_ready = rdy_r;
  assign out_valid = v0_r;
  assign out_data = slot0_r;

  // pop first, then fill the first free slot
  always_comb
  begin
    slot0_nxt = slot0_r;
    slot1_nxt = slot1_r;
    v0_nxt = v0_r;
    v1_nxt = v1_r;
    if (pop)
    begin
      slot0_nxt = slot1_r;
      v0_nxt = v1_r;
      v1_nxt = 1'b0;
    end
    if (push)
    begin
      if (!v0_nxt)
      begin
        slot0_nxt = in_data;
        v0_nxt = 1'b1;
      end
      else
      begin
        slot1_nxt = in_data;
        v1_nxt = 1'b1;
      end
    end
    rdy_nxt = ~v1_nxt; // ready registered, so it lags a pop by one cycle
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      slot0_r <= '0;
      slot1_r <= '0;
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      rdy_r <= 1'b0;
    end
    else
    begin
      slot0_r <= slot0_nxt;
      slot1_r <= slot1_nxt;
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
      rdy_r <= rdy_nxt;
    end
  end

endmodule : t1ld_pair_buf

// ### t1ld_top.sv
// Operation
// - loop-up bit set sends the loop-up code, loop-down bit set sends the loop-down code.
// - framing bit positions carry the framing bit even while a loop code is sent.
// - the loop code lasts while its bit is set and normal payload returns when cleared.
// - both transmit and receive streams are always monitored for ones density.
// - a run of more than 15 zeros is a violation.
// - fewer than N ones in any 8 x (N+1) bit window, N from 1 to 23, is a violation.
// - transmit violations latch in info bit 0, receive violations in info bit 1.
// - with density enforce set the transmit stream is altered so it never violates.
// - a 0-to-1 change of the line interface reset bit resets the line interface.
// - the line interface needs about 40 ms to recover after that reset.
`timescale 1ns/1ps
`include "t1ld_consts.svh"
module t1ld_top #(
  parameter int unsigned LI_RECOVER_CYCLES = `T1LD_LI_RECOVER_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic tx_pay_bit,
  input wire logic tx_frame_pos,
  input wire logic tx_pay_valid,
  output logic tx_pay_ready,
  output logic tx_line_bit,
  output logic tx_line_valid,
  input wire logic tx_line_ready,
  input wire logic rx_line_data,
  input wire logic rx_line_strobe,
  output logic li_reset_pulse,
  output logic li_recovering
);

  logic [7:0] ctl3_r, ctl3_nxt, rdata_r, rdata_nxt;
  logic [1:0] info_r, info_nxt;
  logic [1:0] mon_take, mon_bit, zero_bad, viol;
  t1ld_pkg::t1ld_loop_e loop_mode;
  logic [2:0] up_ph_r, up_ph_nxt;
  logic [1:0] dn_ph_r, dn_ph_nxt;
  logic accept, pre_bit, push_bit, buf_ready;

  // register file on the parallel port
  always_comb
  begin
    ctl3_nxt = ctl3_r;
    info_nxt = info_r;
    rdata_nxt = rdata_r;
    if (bus_wr && bus_addr == `T1LD_CTL3_OFS)
      ctl3_nxt = bus_wdata;
    if (bus_wr && bus_addr == `T1LD_INFO2_OFS)
      info_nxt = info_r & ~bus_wdata[1:0];
    info_nxt = info_nxt | viol; // set beats a same-cycle clear
    if (bus_rd)
    begin
      if (bus_addr == `T1LD_CTL3_OFS)
        rdata_nxt = ctl3_r;
      else if (bus_addr == `T1LD_INFO2_OFS)
        rdata_nxt = {6'h00, info_r};
      else
        rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl3_r <= `T1LD_CTL3_RST;
      info_r <= 2'h0;
      rdata_r <= 8'h00;
    end
    else
    begin
      ctl3_r <= ctl3_nxt;
      info_r <= info_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata = rdata_r;

  // loop code selection; both bits set is illegal, loop-up then wins
  always_comb
  begin
    if (ctl3_r[`T1LD_LUP_BIT])
      loop_mode = t1ld_pkg::T1LD_LOOP_UP;
    else if (ctl3_r[`T1LD_LDN_BIT])
      loop_mode = t1ld_pkg::T1LD_LOOP_DOWN;
    else
      loop_mode = t1ld_pkg::T1LD_LOOP_NONE;
  end

  assign accept = tx_pay_valid & buf_ready;

  // loop code phase, advanced only on payload bits so the code stays aligned
  always_comb
  begin
    up_ph_nxt = up_ph_r;
    dn_ph_nxt = dn_ph_r;
    if (loop_mode != t1ld_pkg::T1LD_LOOP_UP)
      up_ph_nxt = 3'h0;
    else if (accept && !tx_frame_pos)
      up_ph_nxt = (up_ph_r == 3'(`T1LD_LUP_LEN - 1)) ? 3'h0 : up_ph_r + 3'h1;
    if (loop_mode != t1ld_pkg::T1LD_LOOP_DOWN)
      dn_ph_nxt = 2'h0;
    else if (accept && !tx_frame_pos)
      dn_ph_nxt = (dn_ph_r == 2'(`T1LD_LDN_LEN - 1)) ? 2'h0 : dn_ph_r + 2'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      up_ph_r <= 3'h0;
      dn_ph_r <= 2'h0;
    end
    else
    begin
      up_ph_r <= up_ph_nxt;
      dn_ph_r <= dn_ph_nxt;
    end
  end

  // outgoing bit: framing first, then loop code, then payload
  always_comb
  begin
    if (tx_frame_pos)
      pre_bit = tx_pay_bit;
    else
    begin
      case (loop_mode)
        t1ld_pkg::T1LD_LOOP_UP: pre_bit = (up_ph_r == 3'(`T1LD_LUP_LEN - 1));
        t1ld_pkg::T1LD_LOOP_DOWN: pre_bit = (dn_ph_r == 2'(`T1LD_LDN_LEN - 1));
        default: pre_bit = tx_pay_bit;
      endcase
    end
    // a zero that would break density is turned into a one, framing included
    push_bit = pre_bit | (ctl3_r[`T1LD_ENF_BIT] & zero_bad[0]);
  end

  // receive pins cross in through two flops before anything reads them
  logic rx_d_s1, rx_d_s2, rx_k_s1, rx_k_s2, rx_k_s3;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_d_s1 <= 1'b0;
      rx_d_s2 <= 1'b0;
      rx_k_s1 <= 1'b0;
      rx_k_s2 <= 1'b0;
      rx_k_s3 <= 1'b0;
    end
    else
    begin
      rx_d_s1 <= rx_line_data;
      rx_d_s2 <= rx_d_s1;
      rx_k_s1 <= rx_line_strobe;
      rx_k_s2 <= rx_k_s1;
      rx_k_s3 <= rx_k_s2;
    end
  end

  assign mon_take = {rx_k_s2 & ~rx_k_s3, accept};
  assign mon_bit = {rx_d_s2, push_bit};

  // density monitors, index 0 transmit, index 1 receive
  for (genvar s = 0; s < 2; s++)
  begin : g_mon
    logic [`T1LD_HIST_LEN-1:0] hist_r, hist_nxt;
    logic [4:0] zrun_r, zrun_nxt;
    logic [7:0] fill_r, fill_nxt;
    logic [7:0] cnt_r [`T1LD_WIN_N_MAX];
    logic [7:0] cnt_nxt [`T1LD_WIN_N_MAX];
    logic bad;

    // bad means a zero now would violate; a one never can
    always_comb
    begin
      bad = (zrun_r >= 5'(`T1LD_ZERO_RUN_MAX));
      hist_nxt = hist_r;
      zrun_nxt = zrun_r;
      fill_nxt = fill_r;
      for (int n = 1; n <= `T1LD_WIN_N_MAX; n++)
      begin
        cnt_nxt[n-1] = cnt_r[n-1];
        if (fill_r + 8'h01 >= 8'(`T1LD_WIN_UNIT * (n + 1)) &&
            (cnt_r[n-1] - 8'(hist_r[`T1LD_WIN_UNIT * (n + 1) - 1])) < 8'(n))
          bad = 1'b1;
        if (mon_take[s])
          cnt_nxt[n-1] = cnt_r[n-1] + 8'(mon_bit[s]) -
                         8'(hist_r[`T1LD_WIN_UNIT * (n + 1) - 1]);
      end
      if (mon_take[s])
      begin
        hist_nxt = {hist_r[`T1LD_HIST_LEN-2:0], mon_bit[s]};
        if (mon_bit[s])
          zrun_nxt = 5'h00;
        else if (zrun_r != 5'h1f)
          zrun_nxt = zrun_r + 5'h01;
        if (fill_r != 8'(`T1LD_HIST_LEN))
          fill_nxt = fill_r + 8'h01;
      end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        hist_r <= '0;
        zrun_r <= 5'h00;
        fill_r <= 8'h00;
        for (int n = 0; n < `T1LD_WIN_N_MAX; n++)
          cnt_r[n] <= 8'h00;
      end
      else
      begin
        hist_r <= hist_nxt;
        zrun_r <= zrun_nxt;
        fill_r <= fill_nxt;
        cnt_r <= cnt_nxt;
      end
    end

    assign zero_bad[s] = bad;
    assign viol[s] = mon_take[s] & ~mon_bit[s] & bad;
  end

  // two-entry buffer so a stalled encoder loses no bit
  t1ld_pair_buf #(
    .WIDTH(1)
  ) u_txbuf (
    .clk(clk),
    .rstn(rstn),
    .in_valid(tx_pay_valid),
    .in_ready(buf_ready),
    .in_data(push_bit),
    .out_valid(tx_line_valid),
    .out_ready(tx_line_ready),
    .out_data(tx_line_bit)
  );

  assign tx_pay_ready = buf_ready;

  // line interface reset on a rising reset bit, then a recovery window
  t1ld_pkg::t1ld_li_e li_st_r, li_st_nxt;
  logic li_prev_r, li_pulse_r, li_pulse_nxt, li_rec_r;
  logic [31:0] li_cnt_r, li_cnt_nxt;

  always_comb
  begin
    li_pulse_nxt = ctl3_r[`T1LD_LIRESET_BIT] & ~li_prev_r;
    li_st_nxt = li_st_r;
    li_cnt_nxt = li_cnt_r;
    case (li_st_r)
      t1ld_pkg::T1LD_LI_IDLE:
      begin
        if (li_pulse_r)
        begin
          li_st_nxt = t1ld_pkg::T1LD_LI_RECOVER;
          li_cnt_nxt = 32'h0;
        end
      end
      default:
      begin
        // a fresh toggle restarts the wait, it cannot be shortened
        if (li_pulse_r)
          li_cnt_nxt = 32'h0;
        else if (li_cnt_r == LI_RECOVER_CYCLES - 1)
          li_st_nxt = t1ld_pkg::T1LD_LI_IDLE;
        else
          li_cnt_nxt = li_cnt_r + 32'h1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      li_st_r <= t1ld_pkg::T1LD_LI_IDLE;
      li_prev_r <= 1'b0;
      li_pulse_r <= 1'b0;
      li_rec_r <= 1'b0;
      li_cnt_r <= 32'h0;
    end
    else
    begin
      li_st_r <= li_st_nxt;
      li_prev_r <= ctl3_r[`T1LD_LIRESET_BIT];
      li_pulse_r <= li_pulse_nxt;
      li_rec_r <= (li_st_nxt == t1ld_pkg::T1LD_LI_RECOVER);
      li_cnt_r <= li_cnt_nxt;
    end
  end

  assign li_reset_pulse = li_pulse_r;
  assign li_recovering = li_rec_r;

  // checks on the block's own outputs and state
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_loop_up_code: assert property (accept && !tx_frame_pos && ctl3_r[1] && !ctl3_r[3]
    |-> push_bit == (up_ph_r == 3'h4)) else $error("loop-up bit wrong");
  a_loop_down_seq: assert property (accept && !tx_frame_pos && ctl3_r[2]
    && !ctl3_r[1] && !ctl3_r[3] ##1 accept && !tx_frame_pos && ctl3_r[2] && !ctl3_r[1]
    && !ctl3_r[3] |-> dn_ph_r == (($past(dn_ph_r) == 2'h2) ? 2'h0 : $past(dn_ph_r) + 2'h1))
    else $error("loop-down phase wrong");
  a_frame_wins: assert property (accept && tx_frame_pos && !ctl3_r[3]
    |-> push_bit == tx_pay_bit) else $error("framing bit overwritten");
  a_normal_pass: assert property (accept && ctl3_r[3:1] == 3'h0
    |-> push_bit == tx_pay_bit) else $error("payload altered");
  a_run_flag: assert property (mon_take[1] && !rx_d_s2 && g_mon[1].zrun_r == 5'h0f
    |=> info_r[1]) else $error("zero run not flagged");
  a_win_flag: assert property (viol[1] |=> info_r[1] [*2] or
    (info_r[1] ##1 $past(bus_wr))) else $error("rx violation lost");
  a_tx_report: assert property (viol[0] |=> info_r[0])
    else $error("tx violation not reported");
  a_enforce_run: assert property (accept && ctl3_r[3] && g_mon[0].zrun_r == 5'h0f
    |-> push_bit ##1 !viol[0]) else $error("enforcer let a run through");
  a_li_pulse: assert property ($rose(ctl3_r[0])
    |=> li_reset_pulse ##1 !li_reset_pulse) else $error("line reset pulse wrong");
  a_li_hold: assert property (li_reset_pulse |=> li_recovering [*8])
    else $error("recovery window too short");

  c_loop_up: cover property (accept && ctl3_r[1] && push_bit);
  c_rx_viol: cover property (viol[1]);
  c_enforced: cover property (accept && ctl3_r[3] && !pre_bit && push_bit);
  c_stall: cover property (tx_pay_valid && !tx_pay_ready);

endmodule : t1ld_top

// ### t1ld_sink.sv
`timescale 1ns/1ps
module t1ld_sink (
  input wire logic clk,
  input wire logic rstn,
  input wire logic line_bit,
  input wire logic line_valid,
  output logic line_ready,
  input wire logic stall,
  input wire logic slow
);
  logic flip = 1'b0;
  logic got[$];
  // ready moves after the falling edge so the design samples a settled level;
  // slow mode accepts only every other cycle, a stall holds off completely
  always @(negedge clk)
  begin
    flip = !flip;
    line_ready = rstn && !stall && (!slow || flip);
  end
  // keep every accepted bit in arrival order
  always @(posedge clk)
  begin
    if (rstn && line_valid && line_ready)
    begin
      got.push_back(line_bit);
    end
  end
endmodule : t1ld_sink

// ### t1ld_top_tb.sv
`timescale 1ns/1ps
module t1ld_top_tb;
  localparam int REC = 16;
  logic clk, rstn, bus_wr, bus_rd, tx_pay_bit, tx_frame_pos, tx_pay_valid;
  logic tx_pay_ready, tx_line_bit, tx_line_valid, tx_line_ready;
  logic rx_line_data, rx_line_strobe, li_reset_pulse, li_recovering, stall, slow;
  logic [7:0] bus_addr, bus_wdata, bus_rdata;
  int fail_count, comparisons;

  t1ld_top #(.LI_RECOVER_CYCLES(REC)) i_dut (.clk(clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .tx_pay_bit(tx_pay_bit), .tx_frame_pos(tx_frame_pos), .tx_pay_valid(tx_pay_valid),
    .tx_pay_ready(tx_pay_ready), .tx_line_bit(tx_line_bit), .tx_line_valid(tx_line_valid),
    .tx_line_ready(tx_line_ready), .rx_line_data(rx_line_data),
    .rx_line_strobe(rx_line_strobe), .li_reset_pulse(li_reset_pulse),
    .li_recovering(li_recovering));

  t1ld_sink i_sink (.clk(clk), .rstn(rstn), .line_bit(tx_line_bit),
    .line_valid(tx_line_valid), .line_ready(tx_line_ready), .stall(stall), .slow(slow));

  // 40 MHz clock
  always #12.5 clk = !clk;

  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task stop_test;
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test

  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // a spent wait bound ends the run as a failure
  task guard(input int n);
    if (n > 300)
    begin
      fail_count++;
      stop_test();
    end
  endtask : guard

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    tick(1);
    bus_wr = 1'b0;
    tick(1);
  endtask : wr_reg

  // read data is registered, so it is taken one extra cycle later
  task rd_reg(input logic [7:0] a, output logic [7:0] d);
    bus_addr = a;
    bus_rd = 1'b1;
    tick(1);
    bus_rd = 1'b0;
    tick(1);
    d = bus_rdata;
  endtask : rd_reg

  // valid stays up after the handshake so bits can go back to back
  task send(input logic b, input logic f);
    int n;
    n = 0;
    tx_pay_bit = b;
    tx_frame_pos = f;
    tx_pay_valid = 1'b1;
    while (tx_pay_ready !== 1'b1)
    begin
      tick(1);
      n++;
      guard(n);
    end
    tick(1);
  endtask : send

  task drain;
    int n;
    n = 0;
    tx_pay_valid = 1'b0;
    while (tx_line_valid !== 1'b0)
    begin
      tick(1);
      n++;
      guard(n);
    end
  endtask : drain

  task reg_case;
    logic [7:0] d;
    rd_reg(8'h30, d);
    check(d, 8'h00);
    rd_reg(8'h31, d);
    check(d, 8'h00);
    wr_reg(8'h40, 8'hff);
    rd_reg(8'h40, d);
    check(d, 8'h00);
    wr_reg(8'h30, 8'h0a);
    rd_reg(8'h30, d);
    check(d, 8'h0a);
    wr_reg(8'h30, 8'h00);
  endtask : reg_case

  // only a rising edge of the reset bit may restart the recovery wait
  task li_case(input logic [7:0] d, input int ep, input int er);
    int p, r, i;
    p = 0;
    r = 0;
    bus_addr = 8'h30;
    bus_wdata = d;
    bus_wr = 1'b1;
    for (i = 0; i < 40; i++)
    begin
      tick(1);
      bus_wr = 1'b0;
      p += li_reset_pulse;
      r += li_recovering;
    end
    check(8'(p), 8'(ep));
    check(8'(r), 8'(er));
  endtask : li_case

  // framing bit set at index 2 must survive the loop pattern
  task loop_case(input logic [7:0] ctl, input int len);
    int i, p;
    i_sink.got.delete();
    slow = 1'b1;
    wr_reg(8'h30, ctl);
    for (i = 0; i < 12; i++)
    begin
      if (i == 2)
        send(1'b1, 1'b1);
      send(1'b1, 1'b0);
    end
    drain();
    wr_reg(8'h30, 8'h00);
    check(8'(i_sink.got.size()), 8'h0d);
    for (i = 0; i < 13; i++)
    begin
      p = (i > 2) ? i - 1 : i;
      check(8'(i_sink.got[i]), (i == 2) ? 8'h01 : 8'((p % len) == len - 1));
    end
    check(8'(i_sink.got[2]), 8'h01);
    i_sink.got.delete();
    for (i = 0; i < 4; i++)
      send(1'b1, 1'b0);
    drain();
    check(8'(i_sink.got.size() + i_sink.got.sum() with (int'(item))), 8'h08);
    slow = 1'b0;
  endtask : loop_case

  // two-entry buffer takes exactly two bits while the encoder stalls
  task fill_case;
    int n;
    n = 0;
    i_sink.got.delete();
    stall = 1'b1;
    tx_pay_bit = 1'b1;
    tx_pay_valid = 1'b1;
    repeat (8)
    begin
      n += (tx_pay_ready === 1'b1);
      tick(1);
    end
    check(8'(n), 8'h02);
    stall = 1'b0;
    drain();
    check(8'(i_sink.got.size()), 8'h02);
  endtask : fill_case

  // a zeros, then a one if a > 0, then b zeros is clean; one more zero violates
  task tx_case(input int a, input int b);
    logic [7:0] d;
    repeat (40)
      send(1'b1, 1'b0);
    drain();
    wr_reg(8'h31, 8'h03);
    repeat (a)
      send(1'b0, 1'b0);
    if (a > 0)
      send(1'b1, 1'b0);
    repeat (b)
      send(1'b0, 1'b0);
    drain();
    rd_reg(8'h31, d);
    check(d, 8'h00);
    send(1'b0, 1'b0);
    drain();
    rd_reg(8'h31, d);
    check(d, 8'h01);
  endtask : tx_case

  task enforce_case;
    int run, worst;
    logic [7:0] d;
    run = 0;
    worst = 0;
    i_sink.got.delete();
    wr_reg(8'h31, 8'h01);
    wr_reg(8'h30, 8'h08);
    repeat (40)
      send(1'b0, 1'b0);
    drain();
    wr_reg(8'h30, 8'h00);
    rd_reg(8'h31, d);
    check(d, 8'h00);
    foreach (i_sink.got[i])
    begin
      run = (i_sink.got[i] === 1'b0) ? run + 1 : 0;
      worst = (run > worst) ? run : worst;
    end
    check(8'(worst > 15), 8'h00);
  endtask : enforce_case

  // strobes six clocks apart leave room for the two-flop synchroniser
  task rx_bits(input logic v, input int n);
    repeat (n)
    begin
      rx_line_data = v;
      rx_line_strobe = 1'b1;
      tick(3);
      rx_line_strobe = 1'b0;
      tick(3);
    end
  endtask : rx_bits

  task rx_case;
    logic [7:0] d;
    wr_reg(8'h30, 8'h08);
    rx_bits(1'b1, 40);
    wr_reg(8'h31, 8'h03);
    rx_bits(1'b0, 15);
    rd_reg(8'h31, d);
    check(d, 8'h00);
    rx_bits(1'b0, 1);
    rd_reg(8'h31, d);
    check(d, 8'h02);
  endtask : rx_case

  // main sequence
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    {bus_wr, bus_rd, tx_pay_bit, tx_frame_pos, tx_pay_valid} = '0;
    {rx_line_data, rx_line_strobe, stall, slow, bus_addr, bus_wdata} = '0;
    fail_count = 0;
    comparisons = 0;
    tick(16);
    rstn = 1'b1;
    tick(2);
    reg_case();
    li_case(8'h01, 1, REC);
    li_case(8'h01, 0, 0);
    li_case(8'h00, 0, 0);
    li_case(8'h01, 1, REC);
    wr_reg(8'h30, 8'h00);
    fill_case();
    loop_case(8'h02, 5);
    loop_case(8'h04, 3);
    tx_case(0, 15);
    tx_case(8, 14);
    enforce_case();
    rx_case();
    stop_test();
  end

  // overall watchdog
  initial
  begin
    #2000000;
    fail_count++;
    stop_test();
  end
endmodule : t1ld_top_tb
